// *** hw/sram_front.sv ***
// Control-input front end of a pipelined synchronous burst memory
`timescale 1ns/10ps
`include "sram_front_consts.svh"
// ==========================================================
// How it works
// - Address pins registered on each rising edge
// - Lane write enables low write, high read
// - Four lanes, each owning byte and parity
// - Parity bits only in parity configurations
// - Lane writes need master byte enable low
// - Global write writes whole word, ignoring lanes
// - Address, data, enables, strobes registered together
// - Primary enable qualifies processor address strobe
// - Selected only when all three enables valid
// - Enables sampled only on new address loads
// - Snooze request enters data-keeping standby
// - Snooze ignores every other input except the order pin
// - Output enable acts asynchronously on drivers
// - Processor strobe reads; ignored when primary enable high
// - Controller strobe loads or selects power-down
// - Advance low steps burst, high waits
// - Order pin: low linear, high interleaved
module sram_front
   import sram_front_pkg::*;
(
   input  logic         clk,
   input  logic         nrst,
   input  addr_t        address,
   input  word_t        data_in,
   input  lanes_t       lane_write_enables_n,
   input  logic         byte_write_master_n,
   input  logic         full_word_write_n,
   input  logic         primary_select_n,
   input  logic         secondary_select_low,
   input  logic         secondary_select_high,
   input  logic         processor_address_strobe_n,
   input  logic         controller_address_strobe_n,
   input  logic         burst_advance_n,
   input  logic         burst_order_select,
   input  logic         snooze_request,
   input  logic         output_drive_n,
   input  word_t        array_rdata,
   output word_t        data_out,
   output logic         data_oe,
   output addr_t        array_addr,
   output word_t        array_wdata,
   output word_t        array_wmask,
   output logic         array_we,
   output logic         array_re,
   output power_state_t power_state
);
   cycle_bus_if bus ();

   // ==========================================================
   // Pin registers and decode
   pin_capture u_capture (
      .clk                         (clk),
      .nrst                        (nrst),
      .address                     (address),
      .data_in                     (data_in),
      .lane_write_enables_n        (lane_write_enables_n),
      .byte_write_master_n         (byte_write_master_n),
      .full_word_write_n           (full_word_write_n),
      .primary_select_n            (primary_select_n),
      .secondary_select_low        (secondary_select_low),
      .secondary_select_high       (secondary_select_high),
      .processor_address_strobe_n  (processor_address_strobe_n),
      .controller_address_strobe_n (controller_address_strobe_n),
      .burst_advance_n             (burst_advance_n),
      .bus                         (bus)
   );

   // ==========================================================
   // Synchronisers for the asynchronous snooze and static order pins
   logic [`SYNC_N-1:0] zz_sync_reg;
   logic [`SYNC_N-1:0] order_sync_reg;
   logic               snooze_reg;
   logic               linear_reg;

   // A level counts only once stages two and three agree
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         zz_sync_reg    <= '0;
         order_sync_reg <= '1;
         snooze_reg     <= 1'b0;
         linear_reg     <= 1'b0;
      end else begin
         zz_sync_reg    <= {zz_sync_reg[1:0], snooze_request};
         order_sync_reg <= {order_sync_reg[1:0], burst_order_select};
         if (zz_sync_reg[1] == zz_sync_reg[2])
            snooze_reg <= zz_sync_reg[2];
         if (order_sync_reg[1] == order_sync_reg[2])
            linear_reg <= ~order_sync_reg[2];
      end
   end

   // Snooze reaches the synchronous logic four edges late;
   // the drivers are cut straight from the pin to cover that gap
   assign bus.snoozing = snooze_reg;

   // ==========================================================
   // Burst state
   power_state_t power_reg;
   power_state_t power_next;
   addr_t        base_reg;
   burst_t       cnt_reg;
   logic         drive_reg;
   logic         rd_valid_reg;
   logic         we_reg;
   logic         re_reg;
   addr_t        array_addr_reg;
   word_t        wdata_reg;
   word_t        wmask_reg;
   word_t        dout_reg;

   wire is_active = (power_reg == PWR_ACTIVE);
   // Enables are only looked at when a new address is loaded
   wire start     = bus.load & bus.selected;
   wire cont      = ~bus.load & is_active & ~snooze_reg;
   wire step      = cont & bus.advance;
   // Advance held high: address holds; a write may still land
   wire late_wr   = cont & ~bus.advance & bus.write_req;
   wire issue     = start | step | late_wr;
   wire issue_wr  = issue & bus.write_req;
   wire issue_rd  = issue & ~bus.write_req;

   wire addr_t  base_next = start ? bus.addr : base_reg;
   wire burst_t cnt_next  = start ? `BURST_RST
                          : (step ? burst_t'(cnt_reg + 2'h1) : cnt_reg);
   wire burst_t low_next  = burst_step(base_next[1:0], cnt_next,
                                       linear_reg);
   wire addr_t  addr_next = {base_next[`ADDR_W-1:2], low_next};
   // Each lane enable covers its byte and its own parity bit
   wire word_t  mask_next = issue_wr ? lane_bits(bus.lane_mask)
                                     : '0;
   // Drivers stay off across writes and deselect
   wire drive_next = rd_valid_reg ? 1'b1
                   : ((issue_wr | ~is_active) ? 1'b0 : drive_reg);

   // ==========================================================
   // Power state: snooze beats everything, then a new load decides
   always_comb begin
      power_next = power_reg;
      unique case (power_reg)
         PWR_SNOOZE: begin
            if (!snooze_reg)
               power_next = PWR_DOWN;
         end
         PWR_ACTIVE, PWR_DOWN: begin
            if (snooze_reg)
               power_next = PWR_SNOOZE;
            else if (bus.load)
               power_next = bus.selected ? PWR_ACTIVE
                                         : PWR_DOWN;
         end
         default: power_next = PWR_DOWN;
      endcase
   end

   // ==========================================================
   // Burst address and power registers
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         power_reg <= PWR_DOWN;
         base_reg  <= `ADDR_RST;
         cnt_reg   <= `BURST_RST;
      end else begin
         power_reg <= power_next;
         base_reg  <= base_next;
         cnt_reg   <= cnt_next;
      end
   end

   // ==========================================================
   // Array command registers; the array is left untouched in snooze
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         we_reg         <= 1'b0;
         re_reg         <= 1'b0;
         array_addr_reg <= `ADDR_RST;
         wdata_reg      <= `WORD_RST;
         wmask_reg      <= `WORD_RST;
      end else begin
         we_reg         <= issue_wr;
         re_reg         <= issue_rd;
         array_addr_reg <= addr_next;
         wdata_reg      <= bus.wdata;
         wmask_reg      <= mask_next;
      end
   end

   // ==========================================================
   // Read pipeline: array answers one edge after the command
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rd_valid_reg <= 1'b0;
         dout_reg     <= `WORD_RST;
         drive_reg    <= 1'b0;
      end else begin
         rd_valid_reg <= re_reg;
         if (rd_valid_reg)
            dout_reg <= array_rdata;
         drive_reg    <= drive_next;
      end
   end

   // ==========================================================
   // Outputs; the drive enable is deliberately asynchronous
   assign array_we    = we_reg;
   assign array_re    = re_reg;
   assign array_addr  = array_addr_reg;
   assign array_wdata = wdata_reg;
   assign array_wmask = wmask_reg;
   assign data_out    = dout_reg;
   assign power_state = power_reg;
   assign data_oe     = drive_reg & ~output_drive_n
                      & ~snooze_request;

   // ==========================================================
   // Checks
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   sequence zz_held;
      snooze_request [*6];
   endsequence

   sequence rd_then_oe;
      issue_rd ##3 (!output_drive_n && !snooze_request);
   endsequence

   AST_START_ADDR: assert property (
      start |=> (array_we || array_re) &&
                array_addr == $past(bus.addr))
      else $error("loaded address not issued to the array");
   AST_SNOOZE_QUIET: assert property (
      snooze_reg |=> !array_we && !array_re)
      else $error("array accessed during snooze");
   AST_SNOOZE_ENTER: assert property (
      zz_held |-> power_state == PWR_SNOOZE)
      else $error("snooze request did not reach standby");
   AST_BURST_STEP: assert property (
      step |=> array_re || array_we)
      else $error("burst advance issued no access");
   AST_WAIT_HOLD: assert property (
      cont && !bus.advance && !bus.write_req
      |=> !array_re && !array_we && $stable(cnt_reg))
      else $error("wait state moved the burst");
   AST_READ_DRIVE: assert property (
      rd_then_oe |-> data_oe)
      else $error("read data not driven with output enable");
   AST_HIZ: assert property (
      output_drive_n |-> ##1 (output_drive_n -> !data_oe))
      else $error("drivers on while output enable off");
   AST_DESELECT: assert property (
      bus.load && !bus.selected && !snooze_reg
      |=> power_state == PWR_DOWN && !array_we && !array_re)
      else $error("deselect load did not power down");
   AST_READ_DEFAULT: assert property (
      start && !bus.write_req |=> array_re && !array_we)
      else $error("cycle without write not a read");

   // ==========================================================
   // Lane mask, burst and snooze freeze checks

   // Each parity bit follows the first bit of its own lane
   AST_PARITY_LANE: assert property (
      array_wmask[`WORD_W-1:`DATA_W] == {array_wmask[24],
         array_wmask[16], array_wmask[8], array_wmask[0]})
      else $error("parity mask bit differs from its lane");

   // A mask bit outside a write would corrupt the next one
   AST_READ_NO_MASK: assert property (
      !array_we |-> array_wmask == `WORD_RST)
      else $error("write mask set outside a write");

   // Global write reaches every byte and every parity bit
   AST_FULL_MASK: assert property (
      issue_wr && bus.lane_mask == `LANES_OFF_N
      |=> &array_wmask)
      else $error("full word write masked some bits");

   // A continuation never reconsiders the enables
   AST_CONT_ACTIVE: assert property (
      cont |=> power_state == PWR_ACTIVE)
      else $error("enables looked at during a burst");

   // The burst counter only ever touches the two low bits
   AST_BURST_UPPER: assert property (
      step |=> array_addr[`ADDR_W-1:2] == $past(array_addr[`ADDR_W-1:2]))
      else $error("burst step changed the upper address");

   // The order pin settles after reset; require it steady
   AST_LINEAR_STEP: assert property (
      step && linear_reg && $past(linear_reg)
      |=> array_addr[1:0] == burst_t'($past(array_addr[1:0]) + 2'h1))
      else $error("linear burst did not count up");

   // The burst base and counter do not move while in snooze
   AST_SNOOZE_FREEZE: assert property (
      snooze_reg
      |=> $stable(base_reg) && $stable(cnt_reg))
      else $error("burst state moved during snooze");
endmodule : sram_front

// *** hw/sram_front_consts.svh ***
// Constants for the burst memory control-input front end
`ifndef SRAM_FRONT_CONSTS_SVH
`define SRAM_FRONT_CONSTS_SVH
// ==========================================================
// Widths of the wide parity configuration
`define ADDR_W      19
`define LANE_N      4
`define BYTE_W      8
`define DATA_W      32
`define WORD_W      36
`define BURST_W     2
// Parity bits present; clear for the configuration without them
`define HAS_PARITY  1'b1
// ==========================================================
// Synchroniser depth for pins from outside the clock domain
`define SYNC_N      3
// ==========================================================
// Reset values
`define ADDR_RST    19'h00000
`define BURST_RST   2'h0
`define WORD_RST    36'h000000000
`define LANES_OFF_N 4'hf
`endif

// *** hw/sram_front_pkg.sv ***
// Types and helper functions for the memory control-input front end
package sram_front_pkg;
`include "sram_front_consts.svh"

   typedef logic [`ADDR_W-1:0]  addr_t;
   typedef logic [`WORD_W-1:0]  word_t;
   typedef logic [`LANE_N-1:0]  lanes_t;
   typedef logic [`BURST_W-1:0] burst_t;

   // ==========================================================
   // Power state of the memory front end
   typedef enum logic [1:0] {
      PWR_ACTIVE = 2'b00,
      PWR_DOWN   = 2'b01,
      PWR_SNOOZE = 2'b10
   } power_state_t;

   // ==========================================================
   // Expand a lane mask into a word bit mask, parity bits included
   function automatic word_t lane_bits(input lanes_t lanes);
      word_t m;
      m = '0;
      for (int i = 0; i < `LANE_N; i++) begin
         m[i*`BYTE_W +: `BYTE_W] = {`BYTE_W{lanes[i]}};
         m[`DATA_W + i] = lanes[i] & `HAS_PARITY;
      end
      return m;
   endfunction : lane_bits

   // Burst address low bits: linear adds, interleaved xors
   function automatic burst_t burst_step(input burst_t start,
                                         input burst_t cnt,
                                         input logic   linear);
      return linear ? burst_t'(start + cnt) : (start ^ cnt);
   endfunction : burst_step
endpackage : sram_front_pkg

// *** hw/cycle_bus_if.sv ***
// Decoded cycle request passed from pin capture to the core
`timescale 1ns/10ps
`include "sram_front_consts.svh"
interface cycle_bus_if;
   import sram_front_pkg::*;
   logic   load;
   logic   selected;
   logic   write_req;
   logic   advance;
   logic   snoozing;
   lanes_t lane_mask;
   addr_t  addr;
   word_t  wdata;

   modport capture (output load, selected, write_req, advance,
                    lane_mask, addr, wdata, input snoozing);
   modport core    (input load, selected, write_req, advance,
                    lane_mask, addr, wdata, output snoozing);
endinterface : cycle_bus_if

// *** hw/pin_capture.sv ***
// Input registers and cycle decode for the synchronous control pins
`timescale 1ns/10ps
`include "sram_front_consts.svh"
module pin_capture
   import sram_front_pkg::*;
(
   input  logic       clk,
   input  logic       nrst,
   input  addr_t      address,
   input  word_t      data_in,
   input  lanes_t     lane_write_enables_n,
   input  logic       byte_write_master_n,
   input  logic       full_word_write_n,
   input  logic       primary_select_n,
   input  logic       secondary_select_low,
   input  logic       secondary_select_high,
   input  logic       processor_address_strobe_n,
   input  logic       controller_address_strobe_n,
   input  logic       burst_advance_n,
   cycle_bus_if.capture bus
);
   addr_t  addr_reg;
   word_t  wdata_reg;
   lanes_t lane_n_reg;
   logic   master_n_reg;
   logic   full_n_reg;
   logic   prim_n_reg;
   logic   sec_low_reg;
   logic   sec_high_reg;
   logic   proc_n_reg;
   logic   ctrl_n_reg;
   logic   adv_n_reg;

   // ==========================================================
   // All synchronous pins registered together on the rising edge
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         addr_reg     <= `ADDR_RST;
         wdata_reg    <= `WORD_RST;
         lane_n_reg   <= `LANES_OFF_N;
         master_n_reg <= 1'b1;
         full_n_reg   <= 1'b1;
         prim_n_reg   <= 1'b1;
         sec_low_reg  <= 1'b1;
         sec_high_reg <= 1'b0;
         proc_n_reg   <= 1'b1;
         ctrl_n_reg   <= 1'b1;
         adv_n_reg    <= 1'b1;
      end else begin
         addr_reg     <= address;
         wdata_reg    <= data_in;
         lane_n_reg   <= lane_write_enables_n;
         master_n_reg <= byte_write_master_n;
         full_n_reg   <= full_word_write_n;
         prim_n_reg   <= primary_select_n;
         sec_low_reg  <= secondary_select_low;
         sec_high_reg <= secondary_select_high;
         proc_n_reg   <= processor_address_strobe_n;
         ctrl_n_reg   <= controller_address_strobe_n;
         adv_n_reg    <= burst_advance_n;
      end
   end

   // ==========================================================
   // Cycle decode; the processor strobe wins over the controller one
   wire    proc_load = ~proc_n_reg & ~prim_n_reg;
   wire    ctrl_load = ~ctrl_n_reg & ~proc_load;
   wire    lane_on   = ~master_n_reg;
   // Low lane enable means write that lane, high means read
   wire lanes_t lane_req = ~full_n_reg ? `LANES_OFF_N
                         : (lane_on ? ~lane_n_reg : '0);
   assign bus.load      = (proc_load | ctrl_load) & ~bus.snoozing;
   assign bus.selected  = ~prim_n_reg & ~sec_low_reg & sec_high_reg;
   assign bus.lane_mask = lane_req;
   // Processor strobe cycles are always reads
   assign bus.write_req = (|lane_req) & ~proc_load;
   assign bus.advance   = ~adv_n_reg & ~bus.snoozing;
   assign bus.addr      = addr_reg;
   assign bus.wdata     = wdata_reg;

   // ==========================================================
   default clocking cb @(posedge clk); endclocking
   default disable iff (!nrst);

   AST_FULL_WORD: assert property (
      !full_word_write_n |=> bus.lane_mask == `LANES_OFF_N)
      else $error("full word write did not enable every lane");
   AST_MASTER_GATE: assert property (
      byte_write_master_n && full_word_write_n |=> !bus.write_req)
      else $error("lane write without master enable");
   AST_PROC_NEEDS_CE: assert property (
      !processor_address_strobe_n && primary_select_n &&
      controller_address_strobe_n |=> !bus.load)
      else $error("processor strobe taken while deselected");
   AST_SELECT: assert property (
      !primary_select_n && !secondary_select_low &&
      secondary_select_high |=> bus.selected)
      else $error("all enables valid but not selected");
endmodule : pin_capture

// *** testbench/array_model.sv ***
// Behavioural storage array on the far side of the front end
`timescale 1ns/10ps
module array_model
   import sram_front_pkg::*;
(
   input  logic  clk,
   input  addr_t array_addr,
   input  word_t array_wdata,
   input  word_t array_wmask,
   input  logic  array_we,
   input  logic  array_re,
   output word_t array_rdata
);
   // ==========================================================
   // Empty store so unwritten lanes read back as zero
   word_t mem [0:15] = '{default: '0};
   word_t rdata_q    = '0;

   assign array_rdata = rdata_q;

   // ==========================================================
   // Masked write; read answered one edge after the request.
   // Outside an answer the bus toggles so stale data never matches.
   always @(posedge clk) begin
      if (array_we) begin
         mem[array_addr[3:0]] <= (mem[array_addr[3:0]] & ~array_wmask)
                                 | (array_wdata & array_wmask);
      end
      if (array_re) begin
         rdata_q <= mem[array_addr[3:0]];
      end else begin
         rdata_q <= ~rdata_q;
      end
   end
endmodule : array_model

// *** testbench/tb_top.sv ***
// Self-checking bench for the memory control-input front end
`timescale 1ns/10ps
module tb_top;
   import sram_front_pkg::*;
   typedef struct packed {
      logic       ps_n;
      logic       cs_n;
      logic       gw_n;
      logic       bwe_n;
      lanes_t     lw_n;
      logic [2:0] sel;
      logic       we;
      logic       re;
      lanes_t     lanes;
   } row_t;
   logic         clk, nrst, byte_write_master_n, full_word_write_n;
   logic         primary_select_n, secondary_select_low;
   logic         secondary_select_high, processor_address_strobe_n;
   logic         controller_address_strobe_n, burst_advance_n;
   logic         burst_order_select, snooze_request, output_drive_n;
   logic         data_oe, array_we, array_re;
   addr_t        address, array_addr;
   word_t        data_in, array_rdata, data_out, array_wdata, array_wmask;
   lanes_t       lane_write_enables_n;
   power_state_t power_state;
   int           failures = 0;
   int           n_checks = 0;
   int           cycles = 0;
   // Strobe choice, write pins, selects {p_n,s_low,s_high} -> we, re, lanes
   row_t         rows [13] = '{
      '{1, 0, 1, 1, 4'hf, 3'b001, 0, 1, 4'h0},
      '{1, 0, 0, 1, 4'hf, 3'b001, 1, 0, 4'hf},
      '{1, 0, 0, 0, 4'h5, 3'b001, 1, 0, 4'hf},
      '{1, 0, 1, 0, 4'he, 3'b001, 1, 0, 4'h1},
      '{1, 0, 1, 0, 4'h7, 3'b001, 1, 0, 4'h8},
      '{1, 0, 1, 1, 4'h0, 3'b001, 0, 1, 4'h0},
      '{1, 0, 0, 1, 4'hf, 3'b101, 0, 0, 4'h0},
      '{1, 0, 0, 1, 4'hf, 3'b011, 0, 0, 4'h0},
      '{1, 0, 0, 1, 4'hf, 3'b000, 0, 0, 4'h0},
      '{0, 1, 0, 1, 4'hf, 3'b001, 0, 1, 4'h0},
      '{0, 1, 1, 1, 4'hf, 3'b101, 0, 0, 4'h0},
      '{0, 0, 0, 1, 4'hf, 3'b001, 0, 1, 4'h0},
      '{1, 0, 1, 0, 4'h9, 3'b001, 1, 0, 4'h6}};

   sram_front u_dut (.clk(clk), .nrst(nrst), .address(address),
      .data_in(data_in), .lane_write_enables_n(lane_write_enables_n),
      .byte_write_master_n(byte_write_master_n),
      .full_word_write_n(full_word_write_n),
      .primary_select_n(primary_select_n),
      .secondary_select_low(secondary_select_low),
      .secondary_select_high(secondary_select_high),
      .processor_address_strobe_n(processor_address_strobe_n),
      .controller_address_strobe_n(controller_address_strobe_n),
      .burst_advance_n(burst_advance_n),
      .burst_order_select(burst_order_select),
      .snooze_request(snooze_request), .output_drive_n(output_drive_n),
      .array_rdata(array_rdata), .data_out(data_out), .data_oe(data_oe),
      .array_addr(array_addr), .array_wdata(array_wdata),
      .array_wmask(array_wmask), .array_we(array_we),
      .array_re(array_re), .power_state(power_state));

   array_model u_array (.clk(clk), .array_addr(array_addr),
      .array_wdata(array_wdata), .array_wmask(array_wmask),
      .array_we(array_we), .array_re(array_re),
      .array_rdata(array_rdata));

   // ==========================================================
   // Clock and hang guard
   initial begin
      clk = 1'b0;
      forever #12.5 clk = ~clk;
   end

   always @(posedge clk) begin
      cycles++;
      if (cycles == 1500) begin
         failures++;
         end_of_test();
      end
   end

   // ==========================================================
   // Helpers: lane mask expansion and per-row write data
   function automatic word_t expand(input lanes_t l);
      word_t m;
      m = '0;
      for (int i = 0; i < 4; i++) begin
         m[8*i +: 8] = {8{l[i]}};
         m[32+i]     = l[i];
      end
      return m;
   endfunction : expand

   function automatic word_t wdat(input int i);
      return {4'(i), 32'hc0de_0000 | 32'(i)};
   endfunction : wdat

   task automatic cyc();
      @(posedge clk);
      #2;
   endtask : cyc

   // Quiet bus: no strobe, read-level lane enables, device selected
   task automatic idle();
      processor_address_strobe_n  = 1'b1;
      controller_address_strobe_n = 1'b1;
      burst_advance_n             = 1'b1;
      full_word_write_n           = 1'b1;
      byte_write_master_n         = 1'b1;
      lane_write_enables_n        = 4'hf;
      {primary_select_n, secondary_select_low, secondary_select_high} = 3'b001;
   endtask : idle

   task automatic check(input string nm, input word_t seen, input word_t exp);
      n_checks++;
      if (seen !== exp) begin
         failures++;
         $display("BAD %s expected %h seen %h", nm, exp, seen);
      end
   endtask : check

   task automatic end_of_test();
      if (failures == 0 && n_checks > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : end_of_test

   task automatic do_reset();
      nrst = 1'b0;
      repeat (3) cyc();
      nrst = 1'b1;
      cyc();
   endtask : do_reset

   // Read through the processor strobe and compare the returned word
   task automatic rd(input addr_t a, input word_t exp);
      address                    = a;
      processor_address_strobe_n = 1'b0;
      cyc();
      idle();
      repeat (3) cyc();
      check("data_out", data_out, exp);
      check("data_oe", data_oe, 1'b1);
   endtask : rd

   // Load at 5, then continue with the primary select off
   task automatic burst(input addr_t exp);
      address                     = 19'd5;
      controller_address_strobe_n = 1'b0;
      cyc();
      controller_address_strobe_n = 1'b1;
      burst_advance_n             = 1'b0;
      primary_select_n            = 1'b1;
      cyc();
      idle();
      check("load_addr", array_addr, 19'd5);
      cyc();
      check("burst_re", array_re, 1'b1);
      check("burst_addr", array_addr, exp);
      check("burst_pwr", power_state, PWR_ACTIVE);
   endtask : burst

   // ==========================================================
   // Main sequence
   initial begin
      nrst               = 1'b0;
      address            = '0;
      data_in            = '0;
      snooze_request     = 1'b0;
      output_drive_n     = 1'b0;
      burst_order_select = 1'b0;
      idle();
      do_reset();
      check("rst_we", array_we, 1'b0);
      check("rst_oe", data_oe, 1'b0);
      check("rst_pwr", power_state, PWR_DOWN);
      for (int i = 0; i < 13; i++) begin
         processor_address_strobe_n  = rows[i].ps_n;
         controller_address_strobe_n = rows[i].cs_n;
         full_word_write_n           = rows[i].gw_n;
         byte_write_master_n         = rows[i].bwe_n;
         lane_write_enables_n        = rows[i].lw_n;
         {primary_select_n, secondary_select_low,
          secondary_select_high}     = rows[i].sel;
         address                     = 19'(i);
         data_in                     = wdat(i);
         cyc();
         idle();
         cyc();
         check("array_we", array_we, rows[i].we);
         check("array_re", array_re, rows[i].re);
         check("array_wmask", array_wmask, expand(rows[i].lanes));
         if (rows[i].we | rows[i].re) begin
            check("array_addr", array_addr, 19'(i));
         end
         if (rows[i].we) begin
            check("array_wdata", array_wdata, wdat(i));
         end
      end
      rd(19'd2, wdat(2));
      rd(19'd3, wdat(3) & expand(4'h1));
      rd(19'd12, wdat(12) & expand(4'h6));
      output_drive_n = 1'b1;
      repeat (2) cyc();
      check("oe_off", data_oe, 1'b0);
      // Write pins with advance high land at the held burst address
      output_drive_n    = 1'b0;
      full_word_write_n = 1'b0;
      data_in           = wdat(7);
      #1;
      check("oe_on", data_oe, 1'b1);
      cyc();
      idle();
      cyc();
      check("late_we", array_we, 1'b1);
      check("late_addr", array_addr, 19'd12);
      check("late_wdata", array_wdata, wdat(7));
      burst(19'd6);
      // Snooze: drivers drop at once, writes are ignored afterwards
      snooze_request = 1'b1;
      #1;
      check("snooze_oe", data_oe, 1'b0);
      repeat (4) cyc();
      full_word_write_n           = 1'b0;
      controller_address_strobe_n = 1'b0;
      repeat (6) begin
         cyc();
         check("snooze_we", array_we, 1'b0);
      end
      check("snooze_pwr", power_state, PWR_SNOOZE);
      idle();
      snooze_request = 1'b0;
      repeat (6) cyc();
      check("wake_pwr", power_state, PWR_DOWN);
      // Burst order only changes while the part is held in reset
      burst_order_select = 1'b1;
      do_reset();
      check("rst2_oe", data_oe, 1'b0);
      repeat (3) cyc();
      burst(19'd4);
      end_of_test();
   end
endmodule : tb_top
